// file: csa_params.svh
// constants of the chip-select area controller: offsets, fields, resets,
// encodings and timing counts; included by the area controller module only
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH

// register byte offsets
`define CSA_OFF_BUS_CTRL 8'h00
`define CSA_OFF_WAIT_CTRL 8'h04
`define CSA_OFF_PIN_CTRL 8'h08
`define CSA_OFF_STATUS 8'h0C

// field positions
`define CSA_BUS_WIDTH_LSB 9
`define CSA_WRITE_WAIT_LSB 16
`define CSA_SETUP_LSB 11
`define CSA_READ_WAIT_LSB 7
`define CSA_WAIT_MASK_BIT 6
`define CSA_HOLD_LSB 0
`define CSA_PIN_MODE_LSB 2

// reset values
`define CSA_RST_BUS_WIDTH 2'h2
`define CSA_RST_WRITE_WAIT 3'h0
`define CSA_RST_SETUP 2'h1
`define CSA_RST_READ_WAIT 4'h8
`define CSA_RST_WAIT_MASK 1'h0
`define CSA_RST_HOLD 2'h1
`define CSA_RST_PIN_MODE 2'h3

// encodings
`define CSA_WIDTH_8 2'h1
`define CSA_WIDTH_16 2'h2
`define CSA_WW_SAME 3'h0
`define CSA_PIN_CS 2'h3

// timing: one wait cycle is two clocks, so a half wait cycle is one clock
`define CSA_CLK_PER_WAIT 8'h02

`endif

// file: csa_pkg.sv
// types of the chip-select area controller
// assumes csa_params.svh sits in the include path
package csa_pkg;
	typedef enum logic [3:0]
	{
		CSA_IDLE = 4'h1,
		CSA_SETUP = 4'h2,
		CSA_STROBE = 4'h4,
		CSA_HOLD = 4'h8
	} csa_state_t;

	typedef struct packed
	{
		csa_state_t state;
		logic [1:0] bus_width_field;
		logic [2:0] write_wait_field;
		logic [1:0] strobe_setup_field;
		logic [3:0] read_wait_field;
		logic external_wait_mask;
		logic [1:0] strobe_hold_field;
		logic [1:0] pin_mode_field;
		logic [31:0] rdata;
		logic acc_write;
		logic [23:0] acc_addr;
		logic [15:0] acc_wdata;
		logic [15:0] acc_rdata;
		logic acc_done;
		logic busy;
		logic cs_n;
		logic rd_n;
		logic [1:0] we_n;
		logic data_oe;
		logic pin;
		logic wait_s1;
		logic wait_s2;
		logic [15:0] din_s1;
		logic [15:0] din_s2;
	} csa_regs_t;

	typedef struct packed
	{
		logic [7:0] value;
	} csa_cnt_t;
endpackage

// file: csa_timer_if.sv
// carrier between the access sequencer and its phase timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface csa_timer_if;
	logic load;
	logic [7:0] load_val;
	logic zero;
	modport ctl (output load, output load_val, input zero);
	modport cnt (input load, input load_val, output zero);
endinterface

// file: csa_timer.sv
// phase timer: loads a count and steps down to zero once per clock
// assumes a synchronous active-high reset on the same clock
`timescale 1ns/1ps
module csa_timer
	import csa_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control side
	csa_timer_if.cnt tif
);
	csa_cnt_t cur;
	csa_cnt_t next_cnt;

	// load wins, otherwise count down and stop at zero
	always_comb
	begin
		next_cnt = cur;
		if (tif.load)
			next_cnt.value = tif.load_val;
		else if (cur.value != 8'h00)
			next_cnt.value = 8'(cur.value - 8'h01);
	end

	// state register
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cur <= '0;
		else
			cur <= next_cnt;
	end

	assign tif.zero = (cur.value == 8'h00);
endmodule

// file: csa_area_ctrl.sv
// chip-select area controller: registers, access sequencer and pin outputs
// assumes pins I_WAIT_N and I_DATA_IN arrive asynchronously to I_CLK
// Functional notes
// R1 - bus width field 10 selects a 16-bit data bus, both byte lanes
// R2 - write wait field 000 makes writes use the read wait count
// R3 - setup field 01 delays strobes 1.5 wait cycles after chip select
// R4 - read wait field 1000 inserts 10 wait cycles, reads and writes
// R5 - wait mask 0 lets external wait stretch accesses; 1 ignores it
// R6 - hold field 01 keeps chip select 1.5 wait cycles after strobe
// R7 - pin mode 11 routes the area chip select to port pin one
// R8 - select, then strobe, waits plus external wait; data valid by strobe end
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "csa_params.svh"
module csa_area_ctrl
	import csa_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// register port
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	output logic [31:0] O_REG_RDATA,
	// access request port
	input wire logic I_ACC_REQ,
	input wire logic I_ACC_WRITE,
	input wire logic [23:0] I_ACC_ADDR,
	input wire logic [15:0] I_ACC_WDATA,
	output logic O_ACC_BUSY,
	output logic O_ACC_DONE,
	output logic [15:0] O_ACC_RDATA,
	// external bus pins
	output logic [23:0] O_ADDR,
	output logic [15:0] O_DATA_OUT,
	output logic O_DATA_OE,
	input wire logic [15:0] I_DATA_IN,
	output logic O_AREA_CHIP_SELECT_N,
	output logic O_RD_N,
	output logic [1:0] O_BYTE_LANE_STROBE_N,
	input wire logic I_WAIT_N,
	output logic O_PORT_PIN_ONE
);
	csa_regs_t st;
	csa_regs_t next_st;
	logic [7:0] eff_wait;
	csa_timer_if tif ();

	// read wait code to wait cycles
	function automatic logic [7:0] read_waits(input logic [3:0] code);
		logic [7:0] w;
		case (code)
			4'h7: w = 8'h08;
			4'h8: w = 8'h0A; // R4
			4'h9: w = 8'h0C;
			4'hA: w = 8'h0E;
			4'hB: w = 8'h12;
			4'hC: w = 8'h18;
			4'hD: w = 8'h20;
			4'hE: w = 8'h30;
			4'hF: w = 8'h40;
			default: w = {4'h0, code};
		endcase
		return w;
	endfunction

	// strobe length in clocks: (waits + 1) wait cycles
	function automatic logic [7:0] strobe_clks(input logic [7:0] w);
		return 8'((w + 8'h01) * `CSA_CLK_PER_WAIT);
	endfunction

	// wait count of the latched access
	always_comb
	begin
		if (st.acc_write && st.write_wait_field != `CSA_WW_SAME)
			eff_wait = {5'h00, st.write_wait_field};
		else
			eff_wait = read_waits(st.read_wait_field); // R2 R4
	end

	csa_timer u_timer
	(
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.tif (tif.cnt)
	);

	// next state: registers, synchronisers, sequencer, pin values
	always_comb
	begin
		next_st = st;
		next_st.acc_done = 1'b0;
		next_st.rdata = 32'h0000_0000;
		tif.load = 1'b0;
		tif.load_val = 8'h00;
		next_st.wait_s1 = I_WAIT_N;
		next_st.wait_s2 = st.wait_s1;
		next_st.din_s1 = I_DATA_IN;
		next_st.din_s2 = st.din_s1;
		// register writes
		if (I_REG_WR && I_REG_ADDR == `CSA_OFF_BUS_CTRL)
		begin
			next_st.bus_width_field = I_REG_WDATA[`CSA_BUS_WIDTH_LSB +: 2];
		end
		else if (I_REG_WR && I_REG_ADDR == `CSA_OFF_WAIT_CTRL)
		begin
			next_st.write_wait_field = I_REG_WDATA[`CSA_WRITE_WAIT_LSB +: 3];
			next_st.strobe_setup_field = I_REG_WDATA[`CSA_SETUP_LSB +: 2];
			next_st.read_wait_field = I_REG_WDATA[`CSA_READ_WAIT_LSB +: 4];
			next_st.external_wait_mask = I_REG_WDATA[`CSA_WAIT_MASK_BIT];
			next_st.strobe_hold_field = I_REG_WDATA[`CSA_HOLD_LSB +: 2];
		end
		else if (I_REG_WR && I_REG_ADDR == `CSA_OFF_PIN_CTRL)
		begin
			next_st.pin_mode_field = I_REG_WDATA[`CSA_PIN_MODE_LSB +: 2];
		end
		// register reads, unmapped offsets read zero
		if (I_REG_RD && I_REG_ADDR == `CSA_OFF_BUS_CTRL)
			next_st.rdata = {21'h0, st.bus_width_field, 9'h0};
		else if (I_REG_RD && I_REG_ADDR == `CSA_OFF_WAIT_CTRL)
			next_st.rdata = {13'h0, st.write_wait_field, 3'h0,
				st.strobe_setup_field, st.read_wait_field,
				st.external_wait_mask, 4'h0, st.strobe_hold_field};
		else if (I_REG_RD && I_REG_ADDR == `CSA_OFF_PIN_CTRL)
			next_st.rdata = {28'h0, st.pin_mode_field, 2'h0};
		else if (I_REG_RD && I_REG_ADDR == `CSA_OFF_STATUS)
			next_st.rdata = {27'h0, st.state, st.state != CSA_IDLE};
		// access sequencer
		case (st.state)
			CSA_IDLE:
			begin
				if (I_ACC_REQ)
				begin
					next_st.state = CSA_SETUP; // R8
					next_st.acc_write = I_ACC_WRITE;
					next_st.acc_addr = I_ACC_ADDR;
					next_st.acc_wdata = I_ACC_WDATA;
					tif.load = 1'b1;
					tif.load_val = {5'h00, st.strobe_setup_field, 1'b0}; // R3
				end
			end
			CSA_SETUP:
			begin
				if (tif.zero)
				begin
					next_st.state = CSA_STROBE; // R8
					tif.load = 1'b1;
					tif.load_val = 8'(strobe_clks(eff_wait) - 8'h01); // R2 R4
				end
			end
			CSA_STROBE:
			begin
				// external wait holds the strobe unless masked
				if (tif.zero && (st.external_wait_mask || st.wait_s2)) // R5
				begin
					next_st.state = CSA_HOLD;
					tif.load = 1'b1;
					tif.load_val = {5'h00, st.strobe_hold_field, 1'b0}; // R6
					if (!st.acc_write && st.bus_width_field == `CSA_WIDTH_8)
						next_st.acc_rdata = {8'h00, st.din_s2[7:0]};
					else if (!st.acc_write)
						next_st.acc_rdata = st.din_s2; // R8
				end
			end
			CSA_HOLD:
			begin
				if (tif.zero)
				begin
					next_st.state = CSA_IDLE;
					next_st.acc_done = 1'b1;
				end
			end
			default:
			begin
				next_st.state = CSA_IDLE;
			end
		endcase
		// pin values follow the next state so outputs come from flops
		next_st.cs_n = (next_st.state == CSA_IDLE); // R6 R8
		// busy has its own flop so the output is registered
		next_st.busy = (next_st.state != CSA_IDLE);
		next_st.rd_n = !(next_st.state == CSA_STROBE && !next_st.acc_write);
		if (next_st.state == CSA_STROBE && next_st.acc_write
			&& next_st.bus_width_field == `CSA_WIDTH_8)
			next_st.we_n = 2'h2;
		else if (next_st.state == CSA_STROBE && next_st.acc_write)
			next_st.we_n = 2'h0; // R1
		else
			next_st.we_n = 2'h3;
		next_st.data_oe = next_st.acc_write && next_st.state != CSA_IDLE;
		if (next_st.pin_mode_field == `CSA_PIN_CS)
			next_st.pin = next_st.cs_n; // R7
		else
			next_st.pin = 1'b1;
	end

	// state register
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			st <= '0;
			st.state <= CSA_IDLE;
			st.bus_width_field <= `CSA_RST_BUS_WIDTH;
			st.write_wait_field <= `CSA_RST_WRITE_WAIT;
			st.strobe_setup_field <= `CSA_RST_SETUP;
			st.read_wait_field <= `CSA_RST_READ_WAIT;
			st.external_wait_mask <= `CSA_RST_WAIT_MASK;
			st.strobe_hold_field <= `CSA_RST_HOLD;
			st.pin_mode_field <= `CSA_RST_PIN_MODE;
			st.cs_n <= 1'b1;
			st.rd_n <= 1'b1;
			st.we_n <= 2'h3;
			st.pin <= 1'b1;
			st.wait_s1 <= 1'b1;
			st.wait_s2 <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign O_REG_RDATA = st.rdata;
	assign O_ACC_BUSY = st.busy;
	assign O_ACC_DONE = st.acc_done;
	assign O_ACC_RDATA = st.acc_rdata;
	assign O_ADDR = st.acc_addr;
	assign O_DATA_OUT = st.acc_wdata;
	assign O_DATA_OE = st.data_oe;
	assign O_AREA_CHIP_SELECT_N = st.cs_n;
	assign O_RD_N = st.rd_n;
	assign O_BYTE_LANE_STROBE_N = st.we_n;
	assign O_PORT_PIN_ONE = st.pin;

	// phase length helper for the checks below
	logic [7:0] phase_len;
	logic leaving;
	assign leaving = (st.state != next_st.state);
	always_ff @(posedge I_CLK)
	begin
		if (I_RST || leaving)
			phase_len <= 8'h01;
		else
			phase_len <= 8'(phase_len + 8'h01);
	end

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	// checks
	wide_write_lanes_a: assert property ( // R1
		(st.state == CSA_STROBE && st.acc_write && st.bus_width_field == 2'h2)
		|-> O_BYTE_LANE_STROBE_N == 2'h0)
		else $error("16-bit write without both lanes");
	write_wait_same_a: assert property ( // R2
		(st.state == CSA_STROBE && leaving && st.external_wait_mask
		&& st.acc_write && st.write_wait_field == 3'h0)
		|-> phase_len == strobe_clks(read_waits(st.read_wait_field)))
		else $error("write strobe not using read wait");
	setup_delay_a: assert property ( // R3
		(st.state == CSA_SETUP && leaving && st.strobe_setup_field == 2'h1)
		|-> phase_len == 8'h03)
		else $error("setup not 1.5 wait cycles");
	read_wait_ten_a: assert property ( // R4
		(st.state == CSA_STROBE && leaving && st.external_wait_mask
		&& st.read_wait_field == 4'h8 && st.write_wait_field == 3'h0)
		|-> phase_len == 8'h16)
		else $error("strobe not 10 wait cycles");
	ext_wait_hold_a: assert property ( // R5
		(st.state == CSA_STROBE && !st.external_wait_mask && !st.wait_s2)
		|=> st.state == CSA_STROBE)
		else $error("external wait ignored");
	ext_wait_masked_a: assert property ( // R5
		(st.state == CSA_STROBE && st.external_wait_mask && tif.zero)
		|=> st.state == CSA_HOLD)
		else $error("masked wait stretched strobe");
	hold_delay_a: assert property ( // R6
		(st.state == CSA_HOLD && leaving && st.strobe_hold_field == 2'h1)
		|-> phase_len == 8'h03)
		else $error("hold not 1.5 wait cycles");
	pin_routing_a: assert property ( // R7
		(st.pin_mode_field == 2'h3) |-> O_PORT_PIN_ONE == O_AREA_CHIP_SELECT_N)
		else $error("port pin not chip select");
	select_first_a: assert property ( // R8
		($fell(O_RD_N) || $fell(&O_BYTE_LANE_STROBE_N))
		|-> !O_AREA_CHIP_SELECT_N && $past(!O_AREA_CHIP_SELECT_N))
		else $error("strobe without prior chip select");
	// a read strobe never meets a write strobe or driven data
	strobe_exclusive_a: assert property ( // R8
		!O_RD_N |-> &O_BYTE_LANE_STROBE_N && !O_DATA_OE)
		else $error("read and write strobes together");
	addr_held_a: assert property ( // R6
		(!O_AREA_CHIP_SELECT_N && $past(!O_AREA_CHIP_SELECT_N))
		|-> $stable(O_ADDR))
		else $error("address moved while selected");
	cover_read: cover property (O_ACC_DONE && !st.acc_write);
	cover_write: cover property (O_ACC_DONE && st.acc_write);
	cover_short_write: cover property (O_ACC_DONE && st.acc_write
		&& st.write_wait_field != 3'h0);
	cover_stretch: cover property (st.state == CSA_STROBE
		&& !st.external_wait_mask && !st.wait_s2 && tif.zero);
endmodule

// file: csa_dev_model.sv
// behavioural model of the external device host interface on the area
// assumes the controller drives its pins from i_clk
`timescale 1ns/1ps
module csa_dev_model
(
	// clock and control
	input wire logic i_clk,
	input wire logic i_slow,
	// bus pins from the controller
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic [1:0] i_we_n,
	input wire logic [23:0] i_addr,
	input wire logic [15:0] i_data,
	// pins back to the controller
	output logic [15:0] o_data,
	output logic o_wait_n
);
	logic [15:0] mem [0:15];
	int wcnt;
	// known contents so the bench can predict read results
	initial
	begin
		for (int i = 0; i < 16; i++)
			mem[i] = 16'hA5C3 ^ 16'(i);
		o_data = 16'h0000;
		o_wait_n = 1'b1;
		wcnt = 0;
	end
	// drive data only while selected and read-strobed, else a moving pattern
	always @(posedge i_clk)
	begin
		if (!i_cs_n && !i_rd_n)
			o_data <= mem[i_addr[3:0]];
		else
			o_data <= ~o_data;
		for (int k = 0; k < 2; k++)
			if (!i_cs_n && !i_we_n[k])
				mem[i_addr[3:0]][8*k+:8] <= i_data[8*k+:8];
	end
	// in slow mode hold wait low past the nominal strobe end
	always @(posedge i_clk)
	begin
		if (!i_cs_n && (!i_rd_n || i_we_n != 2'b11))
			wcnt <= wcnt + 1;
		else
			wcnt <= 0;
		o_wait_n <= !(i_slow && !i_cs_n && wcnt < 28);
	end
endmodule

// file: testbench.sv
// self-checking bench of the chip-select area controller
// assumes csa_params.svh is in the include path; the model is the far side
`timescale 1ns/1ps
module testbench;
	import csa_pkg::*;
	logic clk, rst, wr, rd, req, wrt, cs_n, rd_n, oe, wait_n, pin, slow;
	logic busy, done;
	logic [7:0] ra;
	logic [31:0] rw, rr;
	logic [23:0] aa, pa;
	logic [15:0] ad, ar, dout, din;
	logic [1:0] we_n;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	csa_area_ctrl uut (.I_CLK(clk), .I_RST(rst), .I_REG_ADDR(ra),
		.I_REG_WDATA(rw), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rr),
		.I_ACC_REQ(req), .I_ACC_WRITE(wrt), .I_ACC_ADDR(aa),
		.I_ACC_WDATA(ad), .O_ACC_BUSY(busy), .O_ACC_DONE(done),
		.O_ACC_RDATA(ar), .O_ADDR(pa), .O_DATA_OUT(dout), .O_DATA_OE(oe),
		.I_DATA_IN(din), .O_AREA_CHIP_SELECT_N(cs_n), .O_RD_N(rd_n),
		.O_BYTE_LANE_STROBE_N(we_n), .I_WAIT_N(wait_n),
		.O_PORT_PIN_ONE(pin));
	csa_dev_model dev (.i_clk(clk), .i_slow(slow), .i_cs_n(cs_n),
		.i_rd_n(rd_n), .i_we_n(we_n), .i_addr(pa), .i_data(dout),
		.o_data(din), .o_wait_n(wait_n));
	// clock of 4 ns
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ends the run with the verdict
	task automatic wrap_up();
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		ra <= a;
		rw <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		ra <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rr;
	endtask
	// one access; n = cycles to done, q = select without strobe,
	// p = cycles where pin differs from select, l = lanes strobed
	task automatic acc(input logic w, input logic [23:0] a,
		input logic [15:0] d, output int n, output int q, output int p,
		output logic [1:0] l);
		int o;
		n = 0;
		q = 0;
		p = 0;
		o = 0;
		l = 2'b00;
		@(posedge clk);
		req <= 1'b1;
		wrt <= w;
		aa <= a;
		ad <= d;
		// the first setup cycle counts as the first of n, the done cycle as the last
		while (n < 200)
		begin
			@(posedge clk);
			req <= 1'b0;
			#1 n++;
			if (cs_n === 1'b0 && rd_n === 1'b1 && we_n === 2'b11)
				q++;
			if (pin !== cs_n)
				p++;
			if (busy !== !cs_n || oe !== (w && !cs_n))
				o++;
			l = l | ~we_n;
			if (done === 1'b1)
				break;
		end
		chk("busy and drive", 0, o);
	endtask
	task automatic t_reset();
		logic [31:0] v;
		reg_rd(8'h00, v);
		chk("bus ctrl", 32'h0000_0400, v);
		reg_rd(8'h04, v);
		chk("wait ctrl", 32'h0000_0C01, v);
		reg_rd(8'h08, v);
		chk("pin ctrl", 32'h0000_000C, v);
		reg_rd(8'h10, v);
		chk("unmapped", 32'h0000_0000, v);
		reg_rd(8'h0C, v);
		chk("status idle", 32'h0000_0002, v);
	endtask
	task automatic t_access();
		int n, q, p;
		logic [1:0] l;
		acc(1'b0, 24'h00_0005, 16'h0000, n, q, p, l);
		chk("read cycles", 29, n);
		chk("setup hold", 6, q);
		chk("pin follows", 0, p);
		chk("read data", {16'h0000, 16'hA5C3 ^ 16'h0005}, {16'h0000, ar});
		acc(1'b1, 24'h00_0006, 16'hBEEF, n, q, p, l);
		chk("write cycles", 29, n);
		chk("write setup hold", 6, q);
		chk("lanes", 2'b11, l);
		acc(1'b0, 24'h00_0006, 16'h0000, n, q, p, l);
		chk("read back", {16'h0000, 16'hBEEF}, {16'h0000, ar});
	endtask
	task automatic t_write_wait();
		int n, q, p;
		logic [1:0] l;
		reg_wr(8'h04, 32'h0001_0C01);
		acc(1'b1, 24'h00_0007, 16'h1234, n, q, p, l);
		chk("short write", 11, n);
		acc(1'b0, 24'h00_0007, 16'h0000, n, q, p, l);
		chk("read keeps", 29, n);
		chk("short data", {16'h0000, 16'h1234}, {16'h0000, ar});
	endtask
	task automatic t_ext_wait();
		int n, q, p;
		logic [1:0] l;
		reg_wr(8'h04, 32'h0000_0C01);
		slow <= 1'b1;
		acc(1'b0, 24'h00_0003, 16'h0000, n, q, p, l);
		chk("stretched", 1, n > 29 && n < 45);
		chk("slow data", {16'h0000, 16'hA5C3 ^ 16'h0003}, {16'h0000, ar});
		reg_wr(8'h04, 32'h0000_0C41);
		acc(1'b0, 24'h00_0003, 16'h0000, n, q, p, l);
		chk("masked", 29, n);
		acc(1'b1, 24'h00_0003, 16'h5A5A, n, q, p, l);
		chk("masked write", 29, n);
		slow <= 1'b0;
	endtask
	task automatic t_width();
		int n, q, p;
		logic [1:0] l;
		reg_wr(8'h00, 32'h0000_0200);
		acc(1'b1, 24'h00_0008, 16'h1122, n, q, p, l);
		chk("narrow lanes", 2'b01, l);
		acc(1'b0, 24'h00_0008, 16'h0000, n, q, p, l);
		chk("narrow data", 32'h0000_0022, {16'h0000, ar});
		reg_wr(8'h00, 32'h0000_0400);
	endtask
	task automatic t_pin();
		int n, q, p;
		logic [1:0] l;
		reg_wr(8'h08, 32'h0000_0000);
		acc(1'b0, 24'h00_0001, 16'h0000, n, q, p, l);
		chk("pin released", 28, p);
		reg_wr(8'h08, 32'h0000_000C);
	endtask
	// main sequence
	initial
	begin
		rst = 1'b1;
		{wr, rd, req, wrt, slow} = 5'b00000;
		ra = 8'h00;
		rw = 32'h0000_0000;
		aa = 24'h00_0000;
		ad = 16'h0000;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_access();
		t_write_wait();
		t_ext_wait();
		t_pin();
		t_width();
		wrap_up();
	end
endmodule
